// [common/dbsh_defines.svh]
// Constants for the DMA bridge bus arbiter and datapath sequencer
// Assumes inclusion by bare name from the design file
`ifndef DBSH_DEFINES_SVH
`define DBSH_DEFINES_SVH
// Bus request codes
`define DBSH_REQ_IDLE      2'h0
`define DBSH_REQ_PREEMPT   2'h1
`define DBSH_REQ_NORMAL    2'h2
`define DBSH_REQ_ATOMIC    2'h3
// Bridge command codes, bridge owns bus
`define DBSH_BC_IDLE       3'h0
`define DBSH_BC_FLUSH      3'h1
`define DBSH_BC_WRITE      3'h2
`define DBSH_BC_WRITE_MASK 3'h3
// Bridge command codes, processor owns bus
`define DBSH_BC_CLR_LOCK   3'h1
`define DBSH_BC_RD_NCHK    3'h2
`define DBSH_BC_RD_CHK     3'h3
// Completion acknowledge codes
`define DBSH_CACK_IDLE     2'h0
`define DBSH_CACK_OK       2'h2
`define DBSH_CACK_ERR      2'h3
// Processor acknowledge codes driven out
`define DBSH_PACK_IDLE     3'h0
`define DBSH_PRD_NCACHE_NCHK 3'h1
`define DBSH_PRD_NCACHE    3'h2
`define DBSH_PCMD_OK       3'h4
`define DBSH_PCMD_HARD_ERR 3'h5
`define DBSH_PCMD_SOFT_ERR 3'h6
`define DBSH_PCMD_STC_FAIL 3'h7
// Datapath commands
`define DBSH_DP_CLEAR      3'h0
`define DBSH_DP_LOAD_PADS  3'h1
`define DBSH_DP_LOAD_DMA_PADS 3'h2
`define DBSH_DP_LOAD_DMA_MEM  3'h3
`define DBSH_SUB_CLEAR     2'h0
`define DBSH_SUB_HOLD      2'h2
`define DBSH_SUB_NONE      2'h0
// Octawords per cache block
`define DBSH_BLOCK_BEATS   2
`endif

// [common/dbsh_pkg.sv]
// Types for the DMA bridge bus arbiter and datapath sequencer
// Assumes dbsh_defines.svh is on the include path
package dbsh_pkg;
    // --------------------------------------------------
    // Datapath command word
    // --------------------------------------------------
    typedef struct packed {
        logic [2:0] cmd;
        logic [1:0] sub;
    } dbsh_dp_cmd_type;

    // --------------------------------------------------
    // Arbiter and transaction states
    // --------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD_WAIT,
        ST_GRANTED,
        ST_READ,
        ST_WRITE,
        ST_DONE
    } dbsh_state_type;
endpackage

// [hdl/dbsh_top.sv]
// Bus arbiter between processor and DMA bridge, with datapath command sequencer
// Assumes all inputs synchronous to I_SYS_CLK; datapath slices consume commands
// Summary of operation
// - Normal request decided by owner and priority
// - Preempt wins; hold request raised at once
// - Grant answers request; bridge stops processor work
// - Processor-owned commands forward acknowledge requests
// - Bridge-owned commands select DMA transaction kind
// - Completion ack: idle, acknowledge, or error
// - Read-data-ready pulses when read data present
// - Read completion means whole block is buffered; flush and write complete without it
// - Drive-data enables datapath bus drivers
// - Control read adds low-half override, own bits
// - Drive-memory-data enables memory bus drive
// - I/O read select and upper octaword select
// - Command 000 clears or holds datapath
// - Commands 001-011 load pads and DMA buffer
`include "dbsh_defines.svh"
module dbsh_top #(
    parameter int BEATS = `DBSH_BLOCK_BEATS
) (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RST_N,
    input  wire logic [1:0]  I_DMA_BUS_REQUEST,
    input  wire logic [2:0]  I_BRIDGE_COMMAND,
    input  wire logic        I_PROCESSOR_CACHE_HOLD_ACK,
    input  wire logic        I_CPU_BUS_REQUEST,
    input  wire logic        I_CPU_XACT_ACTIVE,
    input  wire logic        I_PRIORITY_DMA,
    input  wire logic        I_MEM_READ_VALID,
    input  wire logic        I_MEM_WRITE_DONE,
    input  wire logic        I_MEM_ERROR,
    input  wire logic        I_MEM_WRITE_DRIVE,
    input  wire logic        I_CSR_READ,
    input  wire logic [15:0] I_CSR_DATA,
    input  wire logic        I_IO_READ,
    input  wire logic        I_DATAPATH_READY,
    output logic             O_DMA_BUS_GRANT,
    output logic             O_PROCESSOR_CACHE_HOLD_REQUEST,
    output logic [1:0]       O_DMA_COMPLETION_ACK,
    output logic             O_DMA_READ_DATA_READY,
    output logic [2:0]       O_PROCESSOR_COMMAND_ACK,
    output logic [2:0]       O_PROCESSOR_READ_DATA_ACK,
    output logic             O_CLEAR_LOCK_FLAG,
    output logic             O_MEM_READ_READY,
    output logic             O_DATAPATH_DRIVE_BUS,
    output logic             O_LOW_HALF_OVERRIDE,
    output logic [15:0]      O_CSR_DATA,
    output logic             O_CSR_DATA_OE,
    output logic             O_DATAPATH_DRIVE_MEMORY_BUS,
    output logic             O_IO_READ_BUFFER_SELECT,
    output logic             O_UPPER_OCTAWORD_SELECT,
    output logic [2:0]       O_DATAPATH_COMMAND,
    output logic [1:0]       O_DATAPATH_SUBCOMMAND
);
    // --------------------------------------------------
    // Reset release
    // --------------------------------------------------
    logic rst_meta_reg;
    logic rst_n_reg;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // --------------------------------------------------
    // Declarations
    // --------------------------------------------------
    dbsh_pkg::dbsh_state_type  state_reg;
    dbsh_pkg::dbsh_state_type  state_next;
    dbsh_pkg::dbsh_dp_cmd_type fifo_mem [2];
    dbsh_pkg::dbsh_dp_cmd_type push_data;
    logic                      fifo_wr_reg;
    logic                      fifo_rd_reg;
    logic [1:0]                fifo_cnt_reg;
    logic                      push;
    logic                      pop;
    logic                      fifo_ready;
    logic                      fifo_valid;
    logic [7:0]                beat_reg;
    logic                      err_reg;
    logic                      is_read;
    logic                      req_any;
    logic                      win;
    logic                      own_bus;
    logic                      cmd_start;

    assign req_any    = I_DMA_BUS_REQUEST != `DBSH_REQ_IDLE;
    assign fifo_ready = fifo_cnt_reg != 2'h2;
    assign fifo_valid = fifo_cnt_reg != 2'h0;
    assign own_bus    = O_DMA_BUS_GRANT && I_PROCESSOR_CACHE_HOLD_ACK;
    assign is_read    = I_BRIDGE_COMMAND[2];

    // --------------------------------------------------
    // Arbitration decision
    // --------------------------------------------------
    always_comb begin
        unique case (I_DMA_BUS_REQUEST)
            `DBSH_REQ_PREEMPT: win = 1'b1;
            `DBSH_REQ_NORMAL:  win = !I_CPU_XACT_ACTIVE &&
                                     (!I_CPU_BUS_REQUEST || I_PRIORITY_DMA);
            // Atomic only valid after a grant
            `DBSH_REQ_ATOMIC:  win = 1'b0;
            `DBSH_REQ_IDLE:    win = 1'b0;
        endcase
    end

    // Transaction begins with grant and hold acknowledge
    assign cmd_start = (state_reg == dbsh_pkg::ST_GRANTED) && own_bus &&
                       (I_BRIDGE_COMMAND != `DBSH_BC_IDLE) && fifo_ready;

    // --------------------------------------------------
    // Transaction state machine
    // --------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            dbsh_pkg::ST_IDLE: begin
                if (win) begin
                    state_next = dbsh_pkg::ST_HOLD_WAIT;
                end
            end
            dbsh_pkg::ST_HOLD_WAIT: begin
                // Wait for processor to release cache
                if (I_PROCESSOR_CACHE_HOLD_ACK) begin
                    state_next = dbsh_pkg::ST_GRANTED;
                end
            end
            dbsh_pkg::ST_GRANTED: begin
                if (cmd_start) begin
                    if (is_read) begin
                        state_next = dbsh_pkg::ST_READ;
                    end else if (I_BRIDGE_COMMAND == `DBSH_BC_FLUSH) begin
                        state_next = dbsh_pkg::ST_DONE;
                    end else begin
                        state_next = dbsh_pkg::ST_WRITE;
                    end
                end else if (!req_any) begin
                    state_next = dbsh_pkg::ST_IDLE;
                end
            end
            dbsh_pkg::ST_READ: begin
                if (beat_reg == 8'(BEATS) && fifo_ready) begin
                    state_next = dbsh_pkg::ST_DONE;
                end
            end
            dbsh_pkg::ST_WRITE: begin
                if (I_MEM_WRITE_DONE && fifo_ready) begin
                    state_next = dbsh_pkg::ST_DONE;
                end
            end
            dbsh_pkg::ST_DONE: begin
                // Held request keeps the bus for the next one
                if (req_any) begin
                    state_next = dbsh_pkg::ST_GRANTED;
                end else begin
                    state_next = dbsh_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= dbsh_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // --------------------------------------------------
    // Grant and cache hold request
    // --------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_DMA_BUS_GRANT                <= 1'b0;
            O_PROCESSOR_CACHE_HOLD_REQUEST <= 1'b0;
        end else begin
            // Hold request at once on a win
            O_PROCESSOR_CACHE_HOLD_REQUEST <= state_next != dbsh_pkg::ST_IDLE;
            O_DMA_BUS_GRANT                <= state_next != dbsh_pkg::ST_IDLE;
        end
    end

    // --------------------------------------------------
    // Beat count and error capture
    // --------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            beat_reg <= 8'h00;
            err_reg  <= 1'b0;
        end else if (cmd_start) begin
            beat_reg <= 8'h00;
            err_reg  <= 1'b0;
        end else begin
            if (push && state_reg == dbsh_pkg::ST_READ) begin
                beat_reg <= beat_reg + 8'h01;
            end
            if (I_MEM_ERROR) begin
                err_reg <= 1'b1;
            end
        end
    end

    // --------------------------------------------------
    // Completion acknowledge and read data ready
    // --------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_DMA_COMPLETION_ACK  <= `DBSH_CACK_IDLE;
            O_DMA_READ_DATA_READY <= 1'b0;
            O_MEM_READ_READY      <= 1'b0;
        end else begin
            if (state_next == dbsh_pkg::ST_DONE && state_reg != dbsh_pkg::ST_DONE) begin
                O_DMA_COMPLETION_ACK <= (err_reg || I_MEM_ERROR) ? `DBSH_CACK_ERR
                                                                 : `DBSH_CACK_OK;
            end else begin
                O_DMA_COMPLETION_ACK <= `DBSH_CACK_IDLE;
            end
            O_DMA_READ_DATA_READY <= push && state_reg == dbsh_pkg::ST_READ;
            O_MEM_READ_READY      <= state_next == dbsh_pkg::ST_READ && fifo_ready;
        end
    end

    // --------------------------------------------------
    // Processor acknowledge forwarding
    // --------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_PROCESSOR_COMMAND_ACK   <= `DBSH_PACK_IDLE;
            O_PROCESSOR_READ_DATA_ACK <= `DBSH_PACK_IDLE;
            O_CLEAR_LOCK_FLAG         <= 1'b0;
        end else begin
            O_PROCESSOR_COMMAND_ACK   <= `DBSH_PACK_IDLE;
            O_PROCESSOR_READ_DATA_ACK <= `DBSH_PACK_IDLE;
            O_CLEAR_LOCK_FLAG         <= 1'b0;
            // Ignored while bridge holds or wins the bus
            if (!O_DMA_BUS_GRANT && state_reg == dbsh_pkg::ST_IDLE && !win) begin
                unique case (I_BRIDGE_COMMAND)
                    `DBSH_BC_IDLE:     O_CLEAR_LOCK_FLAG <= 1'b0;
                    `DBSH_BC_CLR_LOCK: O_CLEAR_LOCK_FLAG <= 1'b1;
                    `DBSH_BC_RD_NCHK:  O_PROCESSOR_READ_DATA_ACK <= `DBSH_PRD_NCACHE_NCHK;
                    `DBSH_BC_RD_CHK:   O_PROCESSOR_READ_DATA_ACK <= `DBSH_PRD_NCACHE;
                    3'h4:              O_PROCESSOR_COMMAND_ACK <= `DBSH_PCMD_OK;
                    3'h5:              O_PROCESSOR_COMMAND_ACK <= `DBSH_PCMD_HARD_ERR;
                    3'h6:              O_PROCESSOR_COMMAND_ACK <= `DBSH_PCMD_SOFT_ERR;
                    3'h7:              O_PROCESSOR_COMMAND_ACK <= `DBSH_PCMD_STC_FAIL;
                endcase
            end
        end
    end

    // --------------------------------------------------
    // Datapath command generation
    // --------------------------------------------------
    always_comb begin
        push      = 1'b0;
        push_data = '{cmd: `DBSH_DP_CLEAR, sub: `DBSH_SUB_HOLD};
        if (cmd_start) begin
            push      = 1'b1;
            push_data = '{cmd: `DBSH_DP_CLEAR, sub: `DBSH_SUB_CLEAR};
        end else if (state_reg == dbsh_pkg::ST_READ && I_MEM_READ_VALID &&
                     beat_reg != 8'(BEATS) && fifo_ready) begin
            // Memory read buffer into DMA buffer
            push      = 1'b1;
            push_data = '{cmd: `DBSH_DP_LOAD_DMA_MEM, sub: `DBSH_SUB_NONE};
        end else if (state_reg == dbsh_pkg::ST_WRITE && fifo_ready &&
                     !I_MEM_WRITE_DONE) begin
            push      = 1'b1;
            push_data = '{cmd: `DBSH_DP_LOAD_PADS, sub: `DBSH_SUB_NONE};
        end
    end

    // --------------------------------------------------
    // Two-entry command buffer
    // --------------------------------------------------
    assign pop = fifo_valid && I_DATAPATH_READY;

    for (genvar g = 0; g < 2; g++) begin : g_entry
        always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
            if (!rst_n_reg) begin
                fifo_mem[g] <= '{cmd: `DBSH_DP_CLEAR, sub: `DBSH_SUB_HOLD};
            end else if (push && fifo_wr_reg == 1'(g)) begin
                fifo_mem[g] <= push_data;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            fifo_wr_reg  <= 1'b0;
            fifo_rd_reg  <= 1'b0;
            fifo_cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                fifo_wr_reg <= !fifo_wr_reg;
            end
            if (pop) begin
                fifo_rd_reg <= !fifo_rd_reg;
            end
            if (push && !pop) begin
                fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
            end else if (pop && !push) begin
                fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
            end
        end
    end

    // --------------------------------------------------
    // Datapath command outputs
    // --------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_DATAPATH_COMMAND      <= `DBSH_DP_CLEAR;
            O_DATAPATH_SUBCOMMAND   <= `DBSH_SUB_HOLD;
            O_UPPER_OCTAWORD_SELECT <= 1'b0;
        end else begin
            O_UPPER_OCTAWORD_SELECT <= state_reg == dbsh_pkg::ST_READ && beat_reg[0];
            if (pop) begin
                O_DATAPATH_COMMAND    <= fifo_mem[fifo_rd_reg].cmd;
                O_DATAPATH_SUBCOMMAND <= fifo_mem[fifo_rd_reg].sub;
            end else begin
                O_DATAPATH_COMMAND    <= `DBSH_DP_CLEAR;
                O_DATAPATH_SUBCOMMAND <= `DBSH_SUB_HOLD;
            end
        end
    end

    // --------------------------------------------------
    // Bus drive controls
    // --------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            O_DATAPATH_DRIVE_BUS        <= 1'b0;
            O_LOW_HALF_OVERRIDE         <= 1'b0;
            O_CSR_DATA                  <= 16'h0000;
            O_CSR_DATA_OE               <= 1'b0;
            O_IO_READ_BUFFER_SELECT     <= 1'b0;
            O_DATAPATH_DRIVE_MEMORY_BUS <= 1'b0;
        end else begin
            O_DATAPATH_DRIVE_BUS    <= I_CSR_READ || I_IO_READ;
            O_LOW_HALF_OVERRIDE     <= I_CSR_READ;
            O_CSR_DATA_OE           <= I_CSR_READ;
            O_CSR_DATA              <= I_CSR_READ ? I_CSR_DATA : 16'h0000;
            O_IO_READ_BUFFER_SELECT <= I_IO_READ && !I_CSR_READ;
            O_DATAPATH_DRIVE_MEMORY_BUS <= I_MEM_WRITE_DRIVE;
        end
    end
endmodule

// [verification/dbsh_cpu_model.sv]
// Processor model: gives the cache up when the controller asks
// Assumes the hold request is registered on the same clock
module dbsh_cpu_model (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_hold_request,
    output logic      o_hold_ack
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] lag_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lag_reg <= 2'h0;
        end else begin
            lag_reg <= {lag_reg[0], i_hold_request};
        end
    end
    assign o_hold_ack = lag_reg[1] && i_hold_request;
endmodule

// [verification/dbsh_monitor.sv]
// Concurrent checks on the arbiter, completion and bus drive ports
// Assumes binding into dbsh_top; one clock domain
module dbsh_monitor (
    input wire logic        I_SYS_CLK,
    input wire logic        I_RST_N,
    input wire logic [1:0]  I_DMA_BUS_REQUEST,
    input wire logic        I_CPU_XACT_ACTIVE,
    input wire logic        I_CSR_READ,
    input wire logic [15:0] I_CSR_DATA,
    input wire logic        I_IO_READ,
    input wire logic        I_MEM_WRITE_DRIVE,
    input wire logic        O_DMA_BUS_GRANT,
    input wire logic        O_PROCESSOR_CACHE_HOLD_REQUEST,
    input wire logic [1:0]  O_DMA_COMPLETION_ACK,
    input wire logic        O_DMA_READ_DATA_READY,
    input wire logic [2:0]  O_PROCESSOR_COMMAND_ACK,
    input wire logic        O_LOW_HALF_OVERRIDE,
    input wire logic [15:0] O_CSR_DATA,
    input wire logic        O_CSR_DATA_OE,
    input wire logic        O_DATAPATH_DRIVE_BUS,
    input wire logic        O_DATAPATH_DRIVE_MEMORY_BUS,
    input wire logic        O_IO_READ_BUFFER_SELECT
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    cack_rsvd_a: assert property (O_DMA_COMPLETION_ACK != 2'h1)
        else $error("reserved completion code driven");
    cack_pulse_a: assert property (O_DMA_COMPLETION_ACK != 2'h0 |=> O_DMA_COMPLETION_ACK == 2'h0)
        else $error("completion ack longer than one cycle");
    grant_hold_a: assert property (O_DMA_BUS_GRANT == O_PROCESSOR_CACHE_HOLD_REQUEST)
        else $error("grant and hold request differ");
    preempt_wins_a: assert property (I_DMA_BUS_REQUEST == 2'h1 && !O_DMA_BUS_GRANT |=> O_DMA_BUS_GRANT)
        else $error("preempt not granted at once");
    busy_refuse_a: assert property (I_DMA_BUS_REQUEST == 2'h2 && I_CPU_XACT_ACTIVE && !O_DMA_BUS_GRANT |=> !O_DMA_BUS_GRANT)
        else $error("normal request granted over busy processor");
    ready_owned_a: assert property (O_DMA_READ_DATA_READY |-> O_DMA_BUS_GRANT ##1 !O_DMA_READ_DATA_READY || O_DMA_BUS_GRANT)
        else $error("read ready outside bridge ownership");
    no_cpu_ack_a: assert property (O_DMA_BUS_GRANT && $past(O_DMA_BUS_GRANT) |-> O_PROCESSOR_COMMAND_ACK == 3'h0)
        else $error("processor ack while bridge owns bus");
    csr_drive_a: assert property (I_CSR_READ |=> O_LOW_HALF_OVERRIDE && O_CSR_DATA_OE && O_DATAPATH_DRIVE_BUS && O_CSR_DATA == $past(I_CSR_DATA))
        else $error("control read drive wrong");
    io_select_a: assert property (I_IO_READ && !I_CSR_READ |=> O_IO_READ_BUFFER_SELECT && O_DATAPATH_DRIVE_BUS)
        else $error("io read select missing");
    mem_drive_a: assert property (O_DATAPATH_DRIVE_MEMORY_BUS == $past(I_MEM_WRITE_DRIVE))
        else $error("memory drive does not follow request");
    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    cov_err: cover property (O_DMA_COMPLETION_ACK == 2'h3);
    cov_preempt: cover property (I_DMA_BUS_REQUEST == 2'h1 && I_CPU_XACT_ACTIVE ##1 O_DMA_BUS_GRANT);
    cov_csr: cover property (I_CSR_READ ##1 O_LOW_HALF_OVERRIDE);
endmodule

bind dbsh_top dbsh_monitor i_dbsh_monitor (.*);

// [verification/tb_dbsh_top.sv]
// Self-checking bench for the arbiter and datapath sequencer
// Assumes dbsh_defines.svh on the include path
module tb_dbsh_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BEATS = 2;
    logic        clk, rst_n, cpu_req, cpu_act, prio, mrv, mwd, merr, mdrv, csr, io_rd, dp_rdy;
    logic        hack, grant, hold, rdy, clr, drv, low, csr_oe, drv_mem, io_sel, upper, mrr;
    logic [1:0]  req, cack, dps;
    logic [2:0]  cmd, pcack, prack, dpc;
    logic [15:0] csr_d, csr_o;
    int          miscompares = 0;
    int          checked = 0;
    dbsh_top #(.BEATS(BEATS)) i_dbsh_top (
        .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_DMA_BUS_REQUEST(req), .I_BRIDGE_COMMAND(cmd),
        .I_PROCESSOR_CACHE_HOLD_ACK(hack), .I_CPU_BUS_REQUEST(cpu_req),
        .I_CPU_XACT_ACTIVE(cpu_act), .I_PRIORITY_DMA(prio), .I_MEM_READ_VALID(mrv),
        .I_MEM_WRITE_DONE(mwd), .I_MEM_ERROR(merr), .I_MEM_WRITE_DRIVE(mdrv),
        .I_CSR_READ(csr), .I_CSR_DATA(csr_d), .I_IO_READ(io_rd), .I_DATAPATH_READY(dp_rdy),
        .O_DMA_BUS_GRANT(grant), .O_PROCESSOR_CACHE_HOLD_REQUEST(hold),
        .O_DMA_COMPLETION_ACK(cack), .O_DMA_READ_DATA_READY(rdy),
        .O_PROCESSOR_COMMAND_ACK(pcack), .O_PROCESSOR_READ_DATA_ACK(prack),
        .O_CLEAR_LOCK_FLAG(clr), .O_MEM_READ_READY(mrr), .O_DATAPATH_DRIVE_BUS(drv),
        .O_LOW_HALF_OVERRIDE(low), .O_CSR_DATA(csr_o), .O_CSR_DATA_OE(csr_oe),
        .O_DATAPATH_DRIVE_MEMORY_BUS(drv_mem), .O_IO_READ_BUFFER_SELECT(io_sel),
        .O_UPPER_OCTAWORD_SELECT(upper), .O_DATAPATH_COMMAND(dpc), .O_DATAPATH_SUBCOMMAND(dps));
    dbsh_cpu_model i_dbsh_cpu_model (.i_clk(clk), .i_rst_n(rst_n), .i_hold_request(hold),
        .o_hold_ack(hack));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic timeout_if(input logic done, input string what);
        if (done !== 1'b1) begin
            miscompares++;
            $display("[FAIL] %s wait expired", what);
            end_of_test();
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic dma_xact(input logic [1:0] code, input logic [2:0] op, input logic stall);
        int n;
        int pulses;
        int hits;
        logic up;
        logic rd_rdy;
        pulses = 0;
        hits = 0;
        up = 1'b0;
        rd_rdy = 1'b0;
        // Preempt used only by the preempt scenario
        req = code;
        // Start only with grant and hold acknowledge
        for (n = 0; n < 10 && !(grant && hack); n++) step();
        timeout_if(grant && hack, "grant");
        chk("hold request", 16'h1, 16'(hold));
        step();
        cmd = op;
        // Request back to idle with command
        req = 2'h0;
        merr = (op == 3'h5);
        dp_rdy = !stall;
        step();
        cmd = 3'h0;
        for (n = 0; n < 30 && cack === 2'h0; n++) begin
            mrv = op[2];
            mwd = (n == 4) && !op[2];
            dp_rdy = !stall || n >= 3;
            step();
            // Pulses counted in every transaction, expected only on a read
            pulses += int'(rdy);
            rd_rdy |= mrr;
            hits += int'(dpc === (op[2] ? 3'h3 : 3'h1));
            up |= upper;
        end
        timeout_if(cack !== 2'h0, "completion");
        chk("completion", (op == 3'h5) ? 16'h3 : 16'h2, 16'(cack));
        chk("ready pulses", op[2] ? BEATS : 0, 16'(pulses));
        chk("read ready hint", 16'(op[2]), 16'(rd_rdy));
        mrv = 1'b0;
        mwd = 1'b0;
        merr = 1'b0;
        dp_rdy = 1'b1;
        for (n = 0; n < 5; n++) begin
            step();
            hits += int'(dpc === (op[2] ? 3'h3 : 3'h1));
            up |= upper;
        end
        // Bridge floats address once grant is low
        chk("grant released", 16'h0, 16'(grant));
        chk("upper select", 16'(op[2]), 16'(up));
        if (op[2]) chk("memory loads", BEATS, 16'(hits));
        else if (op != 3'h1) chk("pad loads", 16'h1, 16'(hits > 0));
    endtask
    task automatic refuse_normal();
        cpu_act = 1'b1;
        req = 2'h2;
        repeat (6) step();
        chk("grant busy", 16'h0, 16'(grant));
        cpu_act = 1'b0;
        cpu_req = 1'b1;
        repeat (6) step();
        chk("grant no priority", 16'h0, 16'(grant));
        prio = 1'b1;
        dma_xact(2'h2, 3'h4, 1'b0);
        cpu_req = 1'b0;
        prio = 1'b0;
    endtask
    task automatic proc_acks();
        logic [2:0] c;
        logic [7:0] seen;
        // Acknowledge requests only while bus is idle
        // No cacheable unchecked read acknowledge sent
        for (int k = 1; k < 8; k++) begin
            c = 3'(k);
            seen = 8'h0;
            cmd = c;
            step();
            seen |= {clr, prack, pcack, 1'b0};
            cmd = 3'h0;
            repeat (3) begin
                step();
                seen |= {clr, prack, pcack, 1'b0};
            end
            chk("clear lock", 16'(c == 3'h1), 16'(seen[7]));
            chk("read ack", (c == 3'h2) ? 16'h1 : (c == 3'h3) ? 16'h2 : 16'h0, 16'(seen[6:4]));
            chk("command ack", c[2] ? 16'(c) : 16'h0, 16'(seen[3:1]));
        end
    endtask
    task automatic drive_cmds();
        csr = 1'b1;
        csr_d = 16'hA5C3;
        step();
        chk("csr data", 16'hA5C3, csr_o);
        chk("override", 16'h1, 16'({low, drv, csr_oe} == 3'h7));
        csr = 1'b0;
        io_rd = 1'b1;
        mdrv = 1'b1;
        step();
        chk("io select", 16'h3, 16'({io_sel, drv}));
        chk("override off", 16'h0, 16'(low));
        chk("memory drive", 16'h1, 16'(drv_mem));
        io_rd = 1'b0;
        mdrv = 1'b0;
        step();
        chk("drive off", 16'h0, 16'({drv, drv_mem}));
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_n, cpu_req, cpu_act, prio, mrv, mwd, merr, mdrv, csr, io_rd} = 10'h0;
        {req, cmd, csr_d} = 21'h0;
        dp_rdy = 1'b1;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (3) step();
        chk("idle subcommand", 16'h2, 16'(dps));
        chk("idle grant", 16'h0, 16'(grant));
        // Atomic code only after a grant, never from idle
        for (int k = 1; k < 8; k++) dma_xact(2'h2, 3'(k), 1'b0);
        dma_xact(2'h2, 3'h6, 1'b1);
        cpu_act = 1'b1;
        dma_xact(2'h1, 3'h2, 1'b0);
        cpu_act = 1'b0;
        refuse_normal();
        proc_acks();
        drive_cmds();
        end_of_test();
    end
endmodule
